/* hdl/fir_dev.sv */
// Flash device end: identification, unique serial, parameter table reads,
// software and pin reset, security region erase with one-time locks.
// Assumes the host holds chip select low a few core clocks after the last clock.
`timescale 1ns/1ps
module fir_dev #(
    parameter int ERASE_CYC = 1000,
    parameter logic [7:0] MAKER_CODE = 8'h5e, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h2b, // Arbitrary value
    parameter logic [127:0] UNIQUE_ID = 128'h00112233445566778899aabbccddeeff, // Arbitrary value
    parameter logic [127:0] PARAM_TABLE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
    // Flash link
    fir_link_if.dev link,
    // Core clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Configuration and lock programming
    input wire logic [7:0] nv_cfg,
    input wire logic [2:0] lock_burn,
    // Status and events
    output logic [15:0] status_word,
    output logic [7:0] cfg_word,
    output logic erase_done,
    output logic [1:0] erase_region,
    output logic sw_reset_pulse,
    output logic hw_reset_pulse
);
    logic link_rst_r;
    logic frame_rst;
    logic idle_rst;
    logic [7:0] cfg_r;
    logic [1:0] qpi_sync_r;
    logic quad;
    logic [11:0] clk_cnt_r;
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [11:0] lead;
    logic [11:0] k;
    logic [7:0] idx;
    logic [7:0] rbyte;
    logic [3:0] dq_o_r;
    logic [3:0] dq_oe_n_r;
    fir_pkg::fir_verdict_e verdict_nxt;
    fir_pkg::fir_verdict_e verdict_r;
    logic [1:0] region_r;

    // Frame state clears on deselect; idle state only on resets
    assign frame_rst = link.cs_n | link_rst_r | rst;
    assign idle_rst = link_rst_r | rst;
    assign quad = qpi_sync_r[1];
    assign link.dev_dq_o = dq_o_r;
    assign link.dev_dq_oe_n = dq_oe_n_r;

    // Byte served by a read command
    function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [23:0] a, input logic [7:0] i);
        logic [3:0] p;
        p = a[3:0] + i[3:0];
        case (op)
            fir_pkg::OP_MAKER: read_byte = i[0] ? PART_CODE : MAKER_CODE;
            fir_pkg::OP_UNIQUE: read_byte = UNIQUE_ID[{~p, 3'b111} -: 8];
            fir_pkg::OP_PARAM: read_byte = PARAM_TABLE[{~p, 3'b111} -: 8];
            default: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    // Four-line mode flag into link clock, kept through pin reset so the next frame is not misframed
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            qpi_sync_r <= 2'b00;
        end else begin
            qpi_sync_r <= {qpi_sync_r[0], cfg_r[fir_pkg::CFG_QPI]};
        end
    end

    // Input shifting on rising edges
    assign sh_nxt = quad ? {sh_r[27:0], link.dq} : {sh_r[30:0], link.dq[0]};

    // Command and address capture
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            clk_cnt_r <= 12'h000;
            sh_r <= 32'h0000_0000;
            cmd_r <= 8'h00;
            addr_r <= 24'h00_0000;
        end else begin
            if (clk_cnt_r != 12'hfff) begin
                clk_cnt_r <= clk_cnt_r + 12'h001;
            end
            sh_r <= sh_nxt;
            if (clk_cnt_r == fir_pkg::cmd_clks(quad) - 12'h001) begin
                cmd_r <= sh_nxt[7:0];
            end
            if (clk_cnt_r == fir_pkg::cmd_clks(quad) + fir_pkg::addr_clks(quad) - 12'h001) begin
                addr_r <= sh_nxt[23:0];
            end
        end
    end

    // Position within read data stream
    always_comb begin
        lead = fir_pkg::lead_clks(cmd_r, quad);
        k = clk_cnt_r - lead;
        idx = quad ? k[8:1] : k[10:3];
        rbyte = read_byte(cmd_r, addr_r, idx);
    end

    // Data out on falling edges, released at deselect or reset
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            dq_o_r <= 4'h0;
            dq_oe_n_r <= 4'hf;
        end else if (fir_pkg::is_read(cmd_r) && clk_cnt_r >= lead) begin
            if (quad) begin
                dq_oe_n_r <= 4'h0;
                dq_o_r <= k[0] ? rbyte[3:0] : rbyte[7:4];
            end else begin
                dq_oe_n_r <= 4'b1101;
                dq_o_r <= {2'b00, rbyte[~k[2:0]], 1'b0};
            end
        end
    end

    // Frame outcome from clock count and command
    always_comb begin
        verdict_nxt = fir_pkg::V_OTHER;
        if (clk_cnt_r == fir_pkg::cmd_clks(quad)) begin
            case (cmd_r)
                fir_pkg::OP_WRITE_ENABLE_COMMAND: verdict_nxt = fir_pkg::V_WRITE_ENABLE_COMMAND;
                fir_pkg::OP_ARM: verdict_nxt = fir_pkg::V_ARM;
                fir_pkg::OP_RESET: verdict_nxt = fir_pkg::V_RESET;
                default: verdict_nxt = fir_pkg::V_OTHER;
            endcase
        end else if (cmd_r == fir_pkg::OP_ERASE && clk_cnt_r == fir_pkg::out_clks(cmd_r, quad)
                && fir_pkg::region_ok(addr_r)) begin
            verdict_nxt = fir_pkg::V_ERASE;
        end
    end

    // Outcome held after the frame for the core side
    always_ff @(negedge link.sck or posedge idle_rst) begin
        if (idle_rst) begin
            verdict_r <= fir_pkg::V_NONE;
            region_r <= 2'b00;
        end else begin
            verdict_r <= verdict_nxt;
            region_r <= addr_r[13:12];
        end
    end

    // Core side
    logic [2:0] cs_sync_r;
    logic [1:0] pin_sync_r;
    fir_pkg::fir_verdict_e v_sync1_r;
    fir_pkg::fir_verdict_e v_sync2_r;
    logic [1:0] reg_sync1_r;
    logic [1:0] reg_sync2_r;
    logic cs_rise;
    logic frame_ev;
    logic honoured;
    logic pin_low;
    logic [7:0] low_cnt_r;
    logic hw_start;
    logic arm_r;
    logic sw_fire;
    logic abort;
    logic boot_r;
    logic wel_r;
    logic wip_r;
    logic [31:0] erase_cnt_r;
    logic [2:0] locks_r;
    logic erase_go;

    // Event decode
    assign cs_rise = cs_sync_r[1] & ~cs_sync_r[2];
    assign frame_ev = cs_rise & ~link_rst_r;
    assign honoured = cfg_r[fir_pkg::CFG_DED_RST] | (~cfg_r[fir_pkg::CFG_QPI] & ~cfg_r[fir_pkg::CFG_QE]);
    assign pin_low = honoured & ~pin_sync_r[1];
    assign hw_start = pin_low && low_cnt_r == 8'(fir_pkg::RESET_CYC - 1);
    assign sw_fire = frame_ev && v_sync2_r == fir_pkg::V_RESET && arm_r;
    assign abort = sw_fire | hw_start;
    assign erase_go = frame_ev && v_sync2_r == fir_pkg::V_ERASE && wel_r
        && !wip_r && !locks_r[reg_sync2_r - 2'd1];
    assign status_word = {2'b00, locks_r, 9'h000, wel_r, wip_r};
    assign cfg_word = cfg_r;

    // Synchronisers for chip select, reset pin and frame outcome
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cs_sync_r <= 3'b111;
            pin_sync_r <= 2'b11;
            v_sync1_r <= fir_pkg::V_NONE;
            v_sync2_r <= fir_pkg::V_NONE;
            reg_sync1_r <= 2'b00;
            reg_sync2_r <= 2'b00;
        end else if (clk_en) begin
            cs_sync_r <= {cs_sync_r[1:0], link.cs_n};
            pin_sync_r <= {pin_sync_r[0], link.rst_pin_n};
            v_sync1_r <= verdict_r;
            v_sync2_r <= v_sync1_r;
            reg_sync1_r <= region_r;
            reg_sync2_r <= reg_sync1_r;
        end
    end

    // Pin reset pulse width check and link hold
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_cnt_r <= 8'h00;
            link_rst_r <= 1'b0;
            hw_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            hw_reset_pulse <= hw_start;
            if (!pin_low) begin
                low_cnt_r <= 8'h00;
                link_rst_r <= 1'b0;
            end else begin
                if (low_cnt_r != 8'(fir_pkg::RESET_CYC)) begin
                    low_cnt_r <= low_cnt_r + 8'h01;
                end
                link_rst_r <= link_rst_r | hw_start;
            end
        end
    end

    // Software reset arming
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            arm_r <= 1'b0;
            sw_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            sw_reset_pulse <= sw_fire;
            if (hw_start) begin
                arm_r <= 1'b0;
            end else if (frame_ev) begin
                arm_r <= v_sync2_r == fir_pkg::V_ARM;
            end
        end
    end

    // Volatile configuration, loaded after release and on resets
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r <= fir_pkg::CFG_RESET;
            boot_r <= 1'b0;
        end else if (clk_en) begin
            boot_r <= 1'b1;
            if (!boot_r || abort) begin
                cfg_r <= nv_cfg;
            end
        end
    end

    // One-time region locks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            locks_r <= 3'b000;
        end else if (clk_en) begin
            locks_r <= locks_r | lock_burn;
        end
    end

    // Write enable latch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wel_r <= 1'b0;
        end else if (clk_en) begin
            if (abort || erase_go) begin
                wel_r <= 1'b0;
            end else if (frame_ev && v_sync2_r == fir_pkg::V_WRITE_ENABLE_COMMAND && !wip_r) begin
                wel_r <= 1'b1;
            end
        end
    end

    // Self-timed region erase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wip_r <= 1'b0;
            erase_cnt_r <= 32'h0000_0000;
            erase_done <= 1'b0;
            erase_region <= 2'b00;
        end else if (clk_en) begin
            erase_done <= 1'b0;
            if (abort) begin
                wip_r <= 1'b0;
                erase_cnt_r <= 32'h0000_0000;
            end else if (erase_go) begin
                wip_r <= 1'b1;
                erase_cnt_r <= 32'(ERASE_CYC - 1);
                erase_region <= reg_sync2_r;
            end else if (wip_r) begin
                if (erase_cnt_r == 32'h0000_0000) begin
                    wip_r <= 1'b0;
                    erase_done <= 1'b1;
                end else begin
                    erase_cnt_r <= erase_cnt_r - 32'h0000_0001;
                end
            end
        end
    end
endmodule : fir_dev

/* hdl/fir_pkg.sv */
// Shared constants, verdict type and phase-length helpers of the flash link.
// Assumes both link ends and the bench use the same phase lengths.
package fir_pkg;
    // Command codes
    localparam logic [7:0] OP_MAKER = 8'h90;
    localparam logic [7:0] OP_UNIQUE = 8'h4b;
    localparam logic [7:0] OP_PARAM = 8'h5a;
    localparam logic [7:0] OP_ARM = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OP_ERASE = 8'h44;
    // Phase lengths in link clocks
    localparam logic [11:0] CMD_CLK_1 = 12'h008;
    localparam logic [11:0] CMD_CLK_4 = 12'h002;
    localparam logic [11:0] ADDR_CLK_1 = 12'h018;
    localparam logic [11:0] ADDR_CLK_4 = 12'h006;
    localparam logic [11:0] DUMMY_CLK = 12'h008;
    // Configuration word fields and reset value
    localparam int CFG_QE = 0;
    localparam int CFG_QPI = 1;
    localparam int CFG_DED_RST = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Status word fields
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_LOCK_LSB = 11;
    // Timing
    localparam int CLK_NS = 100;
    localparam int RESET_PULSE_NS = 100;
    localparam int RESET_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
        (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // Outcome of one chip-select frame
    typedef enum logic [2:0] {V_NONE, V_OTHER, V_WRITE_ENABLE_COMMAND, V_ARM, V_RESET, V_ERASE} fir_verdict_e;

    // Command clocks
    function automatic logic [11:0] cmd_clks(input logic q);
        return q ? CMD_CLK_4 : CMD_CLK_1;
    endfunction : cmd_clks

    // Address clocks
    function automatic logic [11:0] addr_clks(input logic q);
        return q ? ADDR_CLK_4 : ADDR_CLK_1;
    endfunction : addr_clks

    // Read commands handled here
    function automatic logic is_read(input logic [7:0] op);
        return op == OP_MAKER || op == OP_UNIQUE || op == OP_PARAM;
    endfunction : is_read

    // Clocks of command plus address
    function automatic logic [11:0] out_clks(input logic [7:0] op, input logic q);
        return cmd_clks(q) + ((is_read(op) || op == OP_ERASE) ? addr_clks(q) : 12'h000);
    endfunction : out_clks

    // Clocks before the first data clock
    function automatic logic [11:0] lead_clks(input logic [7:0] op, input logic q);
        return out_clks(op, q) + ((is_read(op) && op != OP_MAKER) ? DUMMY_CLK : 12'h000);
    endfunction : lead_clks

    // Security region address check
    function automatic logic region_ok(input logic [23:0] a);
        return a[23:16] == 8'h00 && a[15:12] >= 4'h1 && a[15:12] <= 4'h3 && a[11:10] == 2'b00;
    endfunction : region_ok
endpackage : fir_pkg

/* hdl/fir_link_if.sv */
// Flash link wires between host controller and flash device.
// Assumes undriven data lines are pulled high.
`timescale 1ns/1ps
interface fir_link_if;
    logic cs_n;
    logic sck;
    logic rst_pin_n;
    logic [3:0] host_dq_o;
    logic [3:0] host_dq_oe_n;
    logic [3:0] dev_dq_o;
    logic [3:0] dev_dq_oe_n;
    logic [3:0] dq;

    // Resolved line level, pull-up when nobody drives
    assign dq = (~host_dq_oe_n & host_dq_o) | (~dev_dq_oe_n & dev_dq_o) | (host_dq_oe_n & dev_dq_oe_n);

    modport host (output cs_n, output sck, output rst_pin_n, output host_dq_o, output host_dq_oe_n, input dq);
    modport dev (input cs_n, input sck, input rst_pin_n, input dq, output dev_dq_o, output dev_dq_oe_n);
endinterface : fir_link_if

/* hdl/fir_host.sv */
// Host controller end: runs one chip-select frame per request, makes the
// link clock by dividing core_clk, and drives the reset pin on request.
// Assumes the device answers within the low half of each link clock.
`timescale 1ns/1ps
module fir_host #(
    parameter int SCK_HALF = 4,
    parameter int CS_HOLD = 4,
    parameter int CS_GAP = 4,
    parameter int RST_HOLD = fir_pkg::RESET_CYC + 2
) (
    // Flash link
    fir_link_if.host link,
    // Core clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_op,
    input wire logic [23:0] req_addr,
    input wire logic req_quad,
    input wire logic [7:0] req_len,
    input wire logic pin_reset_req,
    // Read data
    output logic rd_valid,
    output logic [7:0] rd_data
);
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP, H_PIN} fir_host_state_e;
    fir_host_state_e state_r;
    logic [7:0] tick_r;
    logic [11:0] idx_r;
    logic [11:0] total_r;
    logic [11:0] lead_r;
    logic [7:0] op_r;
    logic quad_r;
    logic [31:0] tx_r;
    logic cs_n_r;
    logic sck_r;
    logic pin_n_r;
    logic [3:0] dq_o_r;
    logic [3:0] dq_oe_n_r;
    logic [3:0] dq_sync1_r;
    logic [3:0] dq_sync2_r;
    logic [7:0] rx_r;
    logic [3:0] rx_cnt_r;
    logic sample;

    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.rst_pin_n = pin_n_r;
    assign link.host_dq_o = dq_o_r;
    assign link.host_dq_oe_n = dq_oe_n_r;
    assign req_ready = state_r == H_IDLE;
    assign sample = state_r == H_LOW && tick_r == 8'(SCK_HALF - 1) && fir_pkg::is_read(op_r) && idx_r >= lead_r;

    // Line drive {oe_n, data} for link clock i
    function automatic logic [7:0] drive(input logic [31:0] t, input logic [11:0] i, input logic [7:0] op,
                                         input logic q);
        if (i >= fir_pkg::out_clks(op, q)) begin
            drive = {4'hf, 4'h0};
        end else if (q) begin
            drive = {4'h0, t[31:28]};
        end else begin
            drive = {4'b1110, 3'b000, t[31]};
        end
    endfunction : drive

    // Frame length in link clocks
    function automatic logic [11:0] total(input logic [7:0] op, input logic q, input logic [7:0] n);
        if (fir_pkg::is_read(op)) begin
            total = fir_pkg::lead_clks(op, q) + (q ? {3'b000, n, 1'b0} : {1'b0, n, 3'b000});
        end else begin
            total = fir_pkg::out_clks(op, q);
        end
    endfunction : total

    // Frame sequencer and link clock divider
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= H_IDLE;
            tick_r <= 8'h00;
            idx_r <= 12'h000;
            total_r <= 12'h000;
            lead_r <= 12'h000;
            op_r <= 8'h00;
            quad_r <= 1'b0;
            tx_r <= 32'h0000_0000;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
            pin_n_r <= 1'b1;
            dq_o_r <= 4'h0;
            dq_oe_n_r <= 4'hf;
        end else if (clk_en) begin
            tick_r <= tick_r + 8'h01;
            case (state_r)
                H_IDLE: begin
                    tick_r <= 8'h00;
                    if (req_valid) begin
                        cs_n_r <= 1'b0;
                        op_r <= req_op;
                        quad_r <= req_quad;
                        lead_r <= fir_pkg::lead_clks(req_op, req_quad);
                        total_r <= total(req_op, req_quad, req_len);
                        {dq_oe_n_r, dq_o_r} <= drive({req_op, req_addr}, 12'h000, req_op, req_quad);
                        tx_r <= req_quad ? {req_op[3:0], req_addr, 4'h0} : {req_op[6:0], req_addr, 1'b0};
                        idx_r <= 12'h000;
                        state_r <= H_LOW;
                    end else if (pin_reset_req) begin
                        pin_n_r <= 1'b0;
                        state_r <= H_PIN;
                    end
                end
                H_LOW: begin
                    if (tick_r == 8'(SCK_HALF - 1)) begin
                        sck_r <= 1'b1;
                        tick_r <= 8'h00;
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick_r == 8'(SCK_HALF - 1)) begin
                        sck_r <= 1'b0;
                        tick_r <= 8'h00;
                        if (idx_r == total_r - 12'h001) begin
                            {dq_oe_n_r, dq_o_r} <= {4'hf, 4'h0};
                            state_r <= H_HOLD;
                        end else begin
                            idx_r <= idx_r + 12'h001;
                            {dq_oe_n_r, dq_o_r} <= drive(tx_r, idx_r + 12'h001, op_r, quad_r);
                            tx_r <= quad_r ? {tx_r[27:0], 4'h0} : {tx_r[30:0], 1'b0};
                            state_r <= H_LOW;
                        end
                    end
                end
                H_HOLD: begin
                    if (tick_r == 8'(CS_HOLD - 1)) begin
                        cs_n_r <= 1'b1;
                        tick_r <= 8'h00;
                        state_r <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (tick_r == 8'(CS_GAP - 1)) begin
                        state_r <= H_IDLE;
                    end
                end
                H_PIN: begin
                    if (tick_r == 8'(RST_HOLD - 1)) begin
                        pin_n_r <= 1'b1;
                        tick_r <= 8'h00;
                        state_r <= H_GAP;
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    // Read data synchroniser and byte assembly
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_sync1_r <= 4'hf;
            dq_sync2_r <= 4'hf;
            rx_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else if (clk_en) begin
            dq_sync1_r <= link.dq;
            dq_sync2_r <= dq_sync1_r;
            rd_valid <= 1'b0;
            if (state_r == H_IDLE) begin
                rx_cnt_r <= 4'h0;
            end else if (sample) begin
                rx_r <= quad_r ? {rx_r[3:0], dq_sync2_r} : {rx_r[6:0], dq_sync2_r[1]};
                if (rx_cnt_r + (quad_r ? 4'h4 : 4'h1) == 4'h8) begin
                    rd_valid <= 1'b1;
                    rd_data <= quad_r ? {rx_r[3:0], dq_sync2_r} : {rx_r[6:0], dq_sync2_r[1]};
                    rx_cnt_r <= 4'h0;
                end else begin
                    rx_cnt_r <= rx_cnt_r + (quad_r ? 4'h4 : 4'h1);
                end
            end
        end
    end
endmodule : fir_host

/* test/fir_sva.sv */
// Checker of the link between host and device ends.
// Assumes the signals of the interface joining both ends.
`timescale 1ns/1ps
module fir_sva (
    // Clock, reset
    input wire logic core_clk,
    input wire logic rst,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic rst_pin_n,
    input wire logic [3:0] host_dq_oe_n,
    input wire logic [3:0] dev_dq_o,
    input wire logic [3:0] dev_dq_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Drive, release and framing relations
    one_driver_a: assert property ((host_dq_oe_n | dev_dq_oe_n) == 4'hf) else $error("both ends drive");
    desel_quiet_a: assert property (cs_n |-> dev_dq_oe_n == 4'hf) else $error("device drives unselected");
    clock_still_a: assert property (cs_n |-> !sck) else $error("clock runs outside frame");
    fall_change_a: assert property ($changed(dev_dq_o) && !cs_n && rst_pin_n |-> !sck)
        else $error("device data moved off falling edge");
    host_release_a: assert property ($rose(cs_n) |-> host_dq_oe_n == 4'hf) else $error("host drives at end");
    frame_len_a: assert property ($fell(cs_n) |=> !cs_n [*8]) else $error("frame too short");
    lead_quiet_a: assert property ($fell(cs_n) |-> (dev_dq_oe_n == 4'hf) [*8]) else $error("early device data");
    pin_float_a: assert property (!rst_pin_n [*3] |-> dev_dq_oe_n == 4'hf) else $error("drive in pin reset");
    // Main scenarios seen
    cover property ($rose(cs_n));
    cover property (dev_dq_oe_n == 4'h0);
    cover property (!rst_pin_n);
endmodule : fir_sva

/* test/flash_id_reset_secreg_commands_tb.sv */
// Bench joining host and device ends over the link interface.
// Assumes both ends and the checker compile beside it.
`timescale 1ns/1ps
module flash_id_reset_secreg_commands_tb;
    localparam logic [7:0] MK = 8'h3c; // Arbitrary value
    localparam logic [7:0] PT = 8'ha5; // Arbitrary value
    localparam logic [127:0] UID = 128'h8877665544332211f0e0d0c0b0a09080; // Arbitrary value
    localparam logic [127:0] TBL = 128'h0123456789abcdeffedcba9876543210;
    logic core_clk = '0, rst = 1'b1, req_valid = '0, req_quad = '0, pin_reset_req = '0;
    logic req_ready, rd_valid, erase_done, sw_reset_pulse, hw_reset_pulse;
    logic [7:0] req_op = '0, req_len = '0, nv_cfg = 8'h04, rd_data, cfg_word;
    logic [23:0] req_addr = '0;
    logic [2:0] lock_burn = '0;
    logic [15:0] status_word;
    logic [1:0] erase_region;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h1975;
    int fail_count = 0, n_checks = 0, cyc = 0, n_sw = 0, n_hw = 0;
    fir_link_if link ();
    fir_host i_fir_host (.link(link.host), .core_clk, .rst, .clk_en(1'b1), .req_valid, .req_ready, .req_op,
        .req_addr, .req_quad, .req_len, .pin_reset_req, .rd_valid, .rd_data);
    fir_dev #(.ERASE_CYC(200), .MAKER_CODE(MK), .PART_CODE(PT), .UNIQUE_ID(UID), .PARAM_TABLE(TBL)) i_fir_dev (
        .link(link.dev), .core_clk, .rst, .clk_en(1'b1), .nv_cfg, .lock_burn, .status_word, .cfg_word,
        .erase_done, .erase_region, .sw_reset_pulse, .hw_reset_pulse);
    fir_sva i_fir_sva (.core_clk, .rst, .cs_n(link.cs_n), .sck(link.sck), .rst_pin_n(link.rst_pin_n),
        .host_dq_oe_n(link.host_dq_oe_n), .dev_dq_o(link.dev_dq_o), .dev_dq_oe_n(link.dev_dq_oe_n));
    // Core clock
    initial forever #50 core_clk = ~core_clk;
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Report and stop
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // Wait for idle host, then some cycles
    task automatic settle(input int c);
        while (req_ready !== 1'b1) @(posedge core_clk) #1;
        repeat (c) @(posedge core_clk) #1;
    endtask : settle
    // One request; read bytes noted as expected
    task automatic req(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n);
        logic [127:0] t;
        settle(0);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_len = n;
        t = (op == fir_pkg::OP_UNIQUE) ? UID : TBL;
        for (int k = 0; k < n; k++)
            exp_q.push_back(op == fir_pkg::OP_MAKER ? (k[0] ? PT : MK) : t[8 * (15 - (a[3:0] + k) % 16) +: 8]);
        @(posedge core_clk) #1;
        req_valid = 1'b0;
    endtask : req
    // Read data watcher, pulse counts, watchdog
    always @(posedge core_clk) begin
        cyc++;
        if (sw_reset_pulse === 1'b1) n_sw++;
        if (hw_reset_pulse === 1'b1) n_hw++;
        if (rd_valid === 1'b1) chk("rd_data", exp_q.size() ? exp_q.pop_front() : 8'hxx, rd_data);
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        settle(3);
        chk("cfg_word", 16'h0004, cfg_word);
        req(fir_pkg::OP_MAKER, 24'h000000, 8'h05);
        r = rnd();
        req(fir_pkg::OP_UNIQUE, r[23:0], 8'h12);
        req(fir_pkg::OP_PARAM, r[31:8], 8'h03);
        req(fir_pkg::OP_ERASE, 24'h001000, 8'h00);
        settle(2);
        chk("status", 16'h0000, status_word);
        req(fir_pkg::OP_WRITE_ENABLE_COMMAND, 24'h000000, 8'h00);
        req(fir_pkg::OP_ERASE, 24'h002000, 8'h00);
        settle(1);
        chk("status", 16'h0001, status_word);
        for (int t = 0; t < 400 && erase_done !== 1'b1; t++) @(posedge core_clk) #1;
        chk("erase_done", 16'h0001, 16'(erase_done));
        chk("region", 16'h0002, erase_region);
        chk("status", 16'h0000, status_word);
        lock_burn = 3'h4;
        @(posedge core_clk) #1 lock_burn = 3'h0;
        req(fir_pkg::OP_WRITE_ENABLE_COMMAND, 24'h000000, 8'h00);
        req(fir_pkg::OP_ERASE, 24'h003000, 8'h00);
        req(fir_pkg::OP_ERASE, 24'h001400, 8'h00);
        settle(2);
        chk("status", 16'h2002, status_word);
        req(fir_pkg::OP_ARM, 24'h000000, 8'h00);
        req(fir_pkg::OP_WRITE_ENABLE_COMMAND, 24'h000000, 8'h00);
        req(fir_pkg::OP_RESET, 24'h000000, 8'h00);
        settle(2);
        chk("sw_resets", 16'h0000, 16'(n_sw));
        nv_cfg = 8'h06;
        req(fir_pkg::OP_ARM, 24'h000000, 8'h00);
        req(fir_pkg::OP_RESET, 24'h000000, 8'h00);
        settle(4);
        chk("sw_resets", 16'h0001, 16'(n_sw));
        chk("cfg_word", 16'h0006, cfg_word);
        req_quad = 1'b1;
        req(8'h00, 24'h000000, 8'h00);
        req(fir_pkg::OP_WRITE_ENABLE_COMMAND, 24'h000000, 8'h00);
        req(fir_pkg::OP_ERASE, 24'h001000, 8'h00);
        settle(1);
        chk("status", 16'h2001, status_word);
        pin_reset_req = 1'b1;
        @(posedge core_clk) #1 pin_reset_req = 1'b0;
        settle(4);
        chk("hw_resets", 16'h0001, 16'(n_hw));
        chk("status", 16'h2000, status_word);
        r = rnd();
        req(fir_pkg::OP_UNIQUE, r[23:0], 8'h11);
        req(fir_pkg::OP_PARAM, r[31:8], 8'h04);
        req(fir_pkg::OP_MAKER, 24'h000000, 8'h03);
        settle(4);
        chk("left", 16'h0000, 16'(exp_q.size()));
        give_verdict();
    end
endmodule : flash_id_reset_secreg_commands_tb
